// File: usbf_pkg.sv
package usbf_pkg;
  // Word indices of the endpoint-side register port
  localparam logic [4:0] IDX_SEL0 = 5'h00;
  localparam logic [4:0] IDX_SEL1 = 5'h01;
  localparam logic [4:0] IDX_EN0 = 5'h02;
  localparam logic [4:0] IDX_EN1 = 5'h03;
  localparam logic [4:0] IDX_EN2 = 5'h04;
  localparam logic [4:0] IDX_FLG0 = 5'h05;
  localparam logic [4:0] IDX_FLG1 = 5'h06;
  localparam logic [4:0] IDX_FLG2 = 5'h07;
  localparam logic [4:0] IDX_TRIG = 5'h08;
  localparam logic [4:0] IDX_FCLR = 5'h09;
  localparam logic [4:0] IDX_CI_FIFO = 5'h0a;
  localparam logic [4:0] IDX_CO_FIFO = 5'h0b;
  localparam logic [4:0] IDX_SU_FIFO = 5'h0c;
  localparam logic [4:0] IDX_B1_FIFO = 5'h0d;
  localparam logic [4:0] IDX_B2_FIFO = 5'h0e;
  localparam logic [4:0] IDX_I3_FIFO = 5'h0f;
  localparam logic [4:0] IDX_CO_SIZE = 5'h10;
  localparam logic [4:0] IDX_B1_SIZE = 5'h11;
  localparam logic [4:0] IDX_LAST_DEV = 5'h11;
  // Controller-own words on the AXI side
  localparam logic [4:0] IDX_CTRL = 5'h1e;
  localparam logic [4:0] IDX_STATUS = 5'h1f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset values
  localparam logic [7:0] SEL0_RESET = 8'h00;
  localparam logic [7:0] SEL1_RESET = 8'h07;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] SIZE_RESET = 8'h00;
  // First flag group bit positions
  localparam int F0_BUS_RESET = 7;
  localparam int F0_B1_FULL = 6;
  localparam int F0_B2_TREQ = 5;
  localparam int F0_B2_EMPTY = 4;
  localparam int F0_SETUP = 3;
  localparam int F0_CO_DONE = 2;
  localparam int F0_CI_TREQ = 1;
  localparam int F0_CI_DONE = 0;
  // Second and third flag group bit positions
  localparam int F1_I3_TREQ = 2;
  localparam int F1_I3_DONE = 1;
  localparam int F1_CONNECT = 0;
  localparam int F2_SET_CONFIGURATION_SEEN = 0;
  // Trigger bits
  localparam int TRG_CI_COMMIT = 0;
  localparam int TRG_CO_DONE = 1;
  localparam int TRG_B2_COMMIT = 4;
  localparam int TRG_B1_DONE = 5;
  localparam int TRG_I3_COMMIT = 6;
  // FIFO clear bits
  localparam int CLR_CI = 0;
  localparam int CLR_CO = 1;
  localparam int CLR_B1 = 2;
  localparam int CLR_B2 = 3;
  localparam int CLR_I3 = 4;
  // Link-side endpoint codes
  localparam logic [1:0] RX_CTRL_OUT = 2'h0;
  localparam logic [1:0] RX_SETUP = 2'h1;
  localparam logic [1:0] RX_BULK = 2'h2;
  localparam logic [1:0] RX_AUTO = 2'h3;
  localparam logic [1:0] TX_CTRL = 2'h0;
  localparam logic [1:0] TX_BULK = 2'h2;
  localparam logic [1:0] TX_INTR = 2'h3;
  // Buffer sizes in bytes
  localparam logic [6:0] SMALL_PKT = 7'h08;
  localparam logic [6:0] BULK_PKT = 7'h40;
endpackage

// File: usbf_if.sv
`timescale 1ns/10ps
interface usbf_if;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic reg_byte;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic irq_line_zero;
  logic irq_line_one;
  logic irq_line_high_priority;
  modport device (
    input reg_addr, reg_wdata, reg_wr, reg_rd, reg_byte,
    output reg_rdata, reg_rvalid, irq_line_zero, irq_line_one, irq_line_high_priority
  );
  modport controller (
    output reg_addr, reg_wdata, reg_wr, reg_rd, reg_byte,
    input reg_rdata, reg_rvalid, irq_line_zero, irq_line_one, irq_line_high_priority
  );
endinterface

// File: usbf_device.sv
`timescale 1ns/10ps
module usbf_device (
  input wire logic sys_clk,
  input wire logic rst,
  usbf_if.device bus,
  input wire logic bus_reset_event,
  input wire logic connect_event,
  input wire logic set_config_event,
  input wire logic rx_valid,
  input wire logic [1:0] rx_kind,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  input wire logic [1:0] tx_ep,
  input wire logic tx_token,
  input wire logic tx_pop,
  input wire logic tx_ack,
  output logic tx_avail,
  output logic [6:0] tx_len,
  output logic [7:0] tx_data
);
  import usbf_pkg::*;

  typedef struct packed {
    logic [7:0] sel0;
    logic [2:0] sel1;
    logic [7:0] en0;
    logic [2:0] en1;
    logic en2;
    logic [7:0] flg0;
    logic [2:0] flg1;
    logic set_configuration_seen;
    logic [7:0][7:0] ci_mem;
    logic [6:0] ci_len;
    logic ci_ok;
    logic [7:0][7:0] co_mem;
    logic [6:0] co_len;
    logic co_full;
    logic [6:0] co_rd;
    logic [7:0][7:0] su_mem;
    logic [6:0] su_rd;
    logic [127:0][7:0] b1_mem;
    logic [1:0][6:0] b1_len;
    logic [1:0] b1_full;
    logic b1_w;
    logic b1_r;
    logic [6:0] b1_rd;
    logic [127:0][7:0] b2_mem;
    logic [1:0][6:0] b2_len;
    logic [1:0] b2_ok;
    logic b2_w;
    logic b2_t;
    logic [7:0][7:0] i3_mem;
    logic [6:0] i3_len;
    logic i3_ok;
    logic [6:0] rx_ptr;
    logic [6:0] tx_ptr;
    logic [31:0] rdata;
    logic rvalid;
  } dev_state_s;

  dev_state_s s;
  dev_state_s next_s;
  logic [7:0] req0;
  logic [2:0] req1;
  logic [6:0] rx_lim;
  logic [6:0] rx_cnt;
  logic rx_take;

  assign req0 = s.flg0 & s.en0;
  assign req1 = s.flg1 & s.en1;
  // Both lines may be up together; the controller's status word reports each line on its own bit
  assign bus.irq_line_zero = |(req0 & ~s.sel0) | |(req1 & ~s.sel1);
  assign bus.irq_line_one = |(req0 & s.sel0) | |(req1 & s.sel1);
  assign bus.irq_line_high_priority = s.set_configuration_seen & s.en2;
  assign bus.reg_rdata = s.rdata;
  assign bus.reg_rvalid = s.rvalid;

  always_comb begin
    case (rx_kind)
      RX_CTRL_OUT: rx_ready = !s.co_full;
      RX_BULK: rx_ready = !s.b1_full[s.b1_w];
      default: rx_ready = 1'b1;
    endcase
    rx_lim = (rx_kind == RX_BULK) ? BULK_PKT : SMALL_PKT;
    rx_take = rx_valid && rx_ready;
    rx_cnt = (s.rx_ptr < rx_lim) ? s.rx_ptr + 7'h01 : s.rx_ptr;
    case (tx_ep)
      TX_CTRL: begin
        tx_avail = s.ci_ok;
        tx_len = s.ci_len;
        tx_data = s.ci_mem[s.tx_ptr[2:0]];
      end
      TX_BULK: begin
        tx_avail = s.b2_ok[s.b2_t];
        tx_len = s.b2_len[s.b2_t];
        tx_data = s.b2_mem[{s.b2_t, s.tx_ptr[5:0]}];
      end
      TX_INTR: begin
        tx_avail = s.i3_ok;
        tx_len = s.i3_len;
        tx_data = s.i3_mem[s.tx_ptr[2:0]];
      end
      default: begin
        tx_avail = 1'b0;
        tx_len = 7'h00;
        tx_data = 8'h00;
      end
    endcase
  end

  always_comb begin
    logic [31:0] rd;
    logic [31:0] wd;
    rd = 32'h0;
    wd = bus.reg_wdata;
    next_s = s;
    next_s.rvalid = bus.reg_rd;
    if (bus.reg_wr) begin
      case (bus.reg_addr)
        IDX_SEL0: next_s.sel0 = wd[7:0];
        IDX_SEL1: next_s.sel1 = wd[2:0];
        IDX_EN0: next_s.en0 = wd[7:0];
        IDX_EN1: next_s.en1 = wd[2:0];
        IDX_EN2: next_s.en2 = wd[F2_SET_CONFIGURATION_SEEN];
        // Flags clear by writing 0; a set later in this process still wins
        IDX_FLG0: next_s.flg0 = s.flg0 & wd[7:0];
        IDX_FLG1: next_s.flg1 = s.flg1 & wd[2:0];
        IDX_FLG2: next_s.set_configuration_seen = s.set_configuration_seen & wd[F2_SET_CONFIGURATION_SEEN];
        IDX_TRIG: begin
          if (wd[TRG_CI_COMMIT]) next_s.ci_ok = 1'b1;
          if (wd[TRG_I3_COMMIT]) next_s.i3_ok = 1'b1;
          if (wd[TRG_CO_DONE]) begin
            next_s.co_full = 1'b0;
            next_s.co_rd = 7'h00;
          end
          if (wd[TRG_B1_DONE] && s.b1_full[s.b1_r]) begin
            next_s.b1_full[s.b1_r] = 1'b0;
            next_s.b1_r = !s.b1_r;
            next_s.b1_rd = 7'h00;
          end
          if (wd[TRG_B2_COMMIT] && !s.b2_ok[s.b2_w]) begin
            next_s.b2_ok[s.b2_w] = 1'b1;
            next_s.b2_w = !s.b2_w;
          end
        end
        IDX_FCLR: begin
          if (wd[CLR_CI]) begin
            next_s.ci_ok = 1'b0;
            next_s.ci_len = 7'h00;
          end
          if (wd[CLR_CO]) begin
            next_s.co_full = 1'b0;
            next_s.co_rd = 7'h00;
          end
          if (wd[CLR_B1]) begin
            next_s.b1_full = 2'b00;
            next_s.b1_w = 1'b0;
            next_s.b1_r = 1'b0;
            next_s.b1_rd = 7'h00;
          end
          if (wd[CLR_B2]) begin
            next_s.b2_ok = 2'b00;
            next_s.b2_len = '0;
            next_s.b2_w = 1'b0;
            next_s.b2_t = 1'b0;
          end
          if (wd[CLR_I3]) begin
            next_s.i3_ok = 1'b0;
            next_s.i3_len = 7'h00;
          end
        end
        IDX_CI_FIFO: if (!s.ci_ok && s.ci_len < SMALL_PKT) begin
          next_s.ci_mem[s.ci_len[2:0]] = wd[7:0];
          next_s.ci_len = s.ci_len + 7'h01;
        end
        IDX_I3_FIFO: if (!s.i3_ok && s.i3_len < SMALL_PKT) begin
          next_s.i3_mem[s.i3_len[2:0]] = wd[7:0];
          next_s.i3_len = s.i3_len + 7'h01;
        end
        IDX_B2_FIFO: for (int k = 0; k < 4; k++) begin
          // Byte mode stores lane 0 only, one byte per DMA cycle
          if ((k == 0 || !bus.reg_byte) && !s.b2_ok[s.b2_w]
              && next_s.b2_len[s.b2_w] < BULK_PKT) begin
            next_s.b2_mem[{s.b2_w, next_s.b2_len[s.b2_w][5:0]}] = wd[8*k +: 8];
            next_s.b2_len[s.b2_w] = next_s.b2_len[s.b2_w] + 7'h01;
          end
        end
        default: ;
      endcase
    end
    if (bus.reg_rd) begin
      case (bus.reg_addr)
        IDX_SEL0: rd[7:0] = s.sel0;
        IDX_SEL1: rd[2:0] = s.sel1;
        IDX_EN0: rd[7:0] = s.en0;
        IDX_EN1: rd[2:0] = s.en1;
        IDX_EN2: rd[F2_SET_CONFIGURATION_SEEN] = s.en2;
        IDX_FLG0: rd[7:0] = s.flg0;
        IDX_FLG1: rd[2:0] = s.flg1;
        IDX_FLG2: rd[F2_SET_CONFIGURATION_SEEN] = s.set_configuration_seen;
        IDX_CO_SIZE: rd[6:0] = s.co_full ? s.co_len : 7'h00;
        IDX_B1_SIZE: rd[6:0] = s.b1_full[s.b1_r] ? s.b1_len[s.b1_r] : 7'h00;
        IDX_CO_FIFO: if (s.co_full && s.co_rd < s.co_len) begin
          rd[7:0] = s.co_mem[s.co_rd[2:0]];
          next_s.co_rd = s.co_rd + 7'h01;
        end
        IDX_SU_FIFO: if (s.su_rd < SMALL_PKT) begin
          rd[7:0] = s.su_mem[s.su_rd[2:0]];
          next_s.su_rd = s.su_rd + 7'h01;
        end
        IDX_B1_FIFO: for (int k = 0; k < 4; k++) begin
          if ((k == 0 || !bus.reg_byte) && next_s.b1_rd < s.b1_len[s.b1_r]) begin
            rd[8*k +: 8] = s.b1_mem[{s.b1_r, next_s.b1_rd[5:0]}];
            next_s.b1_rd = next_s.b1_rd + 7'h01;
          end
        end
        default: ;
      endcase
    end
    next_s.rdata = rd;
    // Link side after the register side, so hardware sets win over clears
    if (bus_reset_event) next_s.flg0[F0_BUS_RESET] = 1'b1;
    if (connect_event) next_s.flg1[F1_CONNECT] = 1'b1;
    if (set_config_event) next_s.set_configuration_seen = 1'b1;
    if (rx_take) begin
      next_s.rx_ptr = rx_last ? 7'h00 : rx_cnt;
      case (rx_kind)
        RX_CTRL_OUT: begin
          if (s.rx_ptr < SMALL_PKT) next_s.co_mem[s.rx_ptr[2:0]] = rx_data;
          if (rx_last) begin
            next_s.co_full = 1'b1;
            next_s.co_len = rx_cnt;
            next_s.co_rd = 7'h00;
            next_s.flg0[F0_CO_DONE] = 1'b1;
          end
        end
        RX_SETUP: begin
          if (s.rx_ptr < SMALL_PKT) next_s.su_mem[s.rx_ptr[2:0]] = rx_data;
          if (s.rx_ptr == 7'h00) next_s.su_rd = SMALL_PKT;
          if (rx_last) begin
            next_s.su_rd = 7'h00;
            next_s.flg0[F0_SETUP] = 1'b1;
          end
        end
        RX_BULK: begin
          if (s.rx_ptr < BULK_PKT) next_s.b1_mem[{s.b1_w, s.rx_ptr[5:0]}] = rx_data;
          if (rx_last) begin
            next_s.b1_full[s.b1_w] = 1'b1;
            next_s.b1_len[s.b1_w] = rx_cnt;
            next_s.b1_w = !s.b1_w;
            next_s.flg0[F0_B1_FULL] = 1'b1;
          end
        end
        default: ; // Commands the link answers itself are dropped
      endcase
    end
    if (tx_token) begin
      next_s.tx_ptr = 7'h00;
      if (!tx_avail) begin
        case (tx_ep)
          TX_CTRL: next_s.flg0[F0_CI_TREQ] = 1'b1;
          TX_BULK: next_s.flg0[F0_B2_TREQ] = 1'b1;
          TX_INTR: next_s.flg1[F1_I3_TREQ] = 1'b1;
          default: ;
        endcase
      end
    end else if (tx_pop) begin
      next_s.tx_ptr = s.tx_ptr + 7'h01;
    end
    if (tx_ack && tx_avail) begin
      next_s.tx_ptr = 7'h00;
      case (tx_ep)
        TX_CTRL: begin
          next_s.ci_ok = 1'b0;
          next_s.ci_len = 7'h00;
          next_s.flg0[F0_CI_DONE] = 1'b1;
        end
        TX_BULK: begin
          next_s.b2_ok[s.b2_t] = 1'b0;
          // Count freed on ack, so a packet still queued keeps its length
          next_s.b2_len[s.b2_t] = 7'h00;
          next_s.b2_t = !s.b2_t;
          if (!s.b2_ok[!s.b2_t]) next_s.flg0[F0_B2_EMPTY] = 1'b1;
        end
        TX_INTR: begin
          next_s.i3_ok = 1'b0;
          next_s.i3_len = 7'h00;
          next_s.flg1[F1_I3_DONE] = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.sel0 <= SEL0_RESET;
      s.sel1 <= SEL1_RESET[2:0];
      s.en0 <= EN_RESET;
      s.en1 <= EN_RESET[2:0];
      s.en2 <= EN_RESET[0];
      s.co_len <= SIZE_RESET[6:0];
      s.su_rd <= SMALL_PKT;
    end else begin
      s <= next_s;
    end
  end
endmodule

// File: usbf_controller.sv
`timescale 1ns/10ps
module usbf_controller (
  input wire logic sys_clk,
  input wire logic rst,
  usbf_if.controller dev,
  input wire logic [6:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [6:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import usbf_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RWAIT = 4'b0010,
    ST_BRESP = 4'b0100,
    ST_RRESP = 4'b1000
  } ctl_state_e;

  typedef struct packed {
    ctl_state_e st;
    logic aw_got;
    logic w_got;
    logic [4:0] waddr;
    logic [31:0] wdata;
    logic [4:0] addr;
    logic [31:0] data;
    logic wr;
    logic rd;
    logic byte_mode;
    logic [1:0] resp;
  } ctl_state_s;

  ctl_state_s s;
  ctl_state_s next_s;

  assign s_axi_awready = (s.st == ST_IDLE) && !s.aw_got;
  assign s_axi_wready = (s.st == ST_IDLE) && !s.w_got;
  // Reads wait while a write is half taken, keeping one access in flight
  assign s_axi_arready = (s.st == ST_IDLE) && !s.aw_got && !s.w_got;
  assign s_axi_bvalid = (s.st == ST_BRESP);
  assign s_axi_rvalid = (s.st == ST_RRESP);
  assign s_axi_bresp = s.resp;
  assign s_axi_rresp = s.resp;
  assign s_axi_rdata = s.data;
  assign dev.reg_addr = s.addr;
  assign dev.reg_wdata = s.data;
  assign dev.reg_wr = s.wr;
  assign dev.reg_rd = s.rd;
  // Byte mode lets a DMA move one byte per access through the bulk ports
  assign dev.reg_byte = s.byte_mode;

  always_comb begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    case (s.st)
      ST_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          next_s.aw_got = 1'b1;
          next_s.waddr = s_axi_awaddr[6:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
          next_s.w_got = 1'b1;
          next_s.wdata = s_axi_wdata;
        end
        if (s.aw_got && s.w_got) begin
          next_s.aw_got = 1'b0;
          next_s.w_got = 1'b0;
          next_s.st = ST_BRESP;
          next_s.resp = RESP_OKAY;
          next_s.addr = s.waddr;
          next_s.data = s.wdata;
          if (s.waddr <= IDX_LAST_DEV) begin
            next_s.wr = 1'b1;
          end else if (s.waddr == IDX_CTRL) begin
            next_s.byte_mode = s.wdata[0];
          end else if (s.waddr != IDX_STATUS) begin
            next_s.resp = RESP_SLVERR;
          end
        end else if (s_axi_arvalid && s_axi_arready) begin
          next_s.addr = s_axi_araddr[6:2];
          next_s.resp = RESP_OKAY;
          next_s.data = 32'h0;
          if (s_axi_araddr[6:2] <= IDX_LAST_DEV) begin
            next_s.rd = 1'b1;
            next_s.st = ST_RWAIT;
          end else begin
            next_s.st = ST_RRESP;
            if (s_axi_araddr[6:2] == IDX_CTRL) begin
              next_s.data[0] = s.byte_mode;
            end else if (s_axi_araddr[6:2] == IDX_STATUS) begin
              next_s.data[2:0] = {dev.irq_line_high_priority, dev.irq_line_one,
                                  dev.irq_line_zero};
            end else begin
              next_s.resp = RESP_SLVERR;
            end
          end
        end
      end
      ST_RWAIT: if (dev.reg_rvalid) begin
        next_s.data = dev.reg_rdata;
        next_s.st = ST_RRESP;
      end
      ST_BRESP: if (s_axi_bready) next_s.st = ST_IDLE;
      ST_RRESP: if (s_axi_rready) next_s.st = ST_IDLE;
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.st <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end
endmodule

// File: usbf_props.sv
`timescale 1ns/10ps
module usbf_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_byte,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic irq_line_zero,
  input wire logic irq_line_one,
  input wire logic irq_line_high_priority
);
  import usbf_pkg::*;
  // Shadow of routing and enables, rebuilt from port writes
  typedef struct packed {
    logic [7:0] sel0;
    logic [2:0] sel1;
    logic [7:0] en0;
    logic [2:0] en1;
    logic en2;
  } shadow_s;
  shadow_s sh;
  shadow_s next_sh;
  always_comb begin
    next_sh = sh;
    if (reg_wr) begin
      case (reg_addr)
        IDX_SEL0: next_sh.sel0 = reg_wdata[7:0];
        IDX_SEL1: next_sh.sel1 = reg_wdata[2:0];
        IDX_EN0: next_sh.en0 = reg_wdata[7:0];
        IDX_EN1: next_sh.en1 = reg_wdata[2:0];
        IDX_EN2: next_sh.en2 = reg_wdata[0];
        default: ;
      endcase
    end
    if (rst) begin
      next_sh = {SEL0_RESET, SEL1_RESET[2:0], EN_RESET, 3'h0, 1'b0};
    end
  end
  always_ff @(posedge sys_clk) begin
    sh <= next_sh;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence rd_at(logic [4:0] a);
    reg_rd && reg_addr == a;
  endsequence
  chk_reset_quiet: assert property (
    $fell(rst) |-> !irq_line_zero && !irq_line_one && !irq_line_high_priority)
    else $error("irq line high after reset");
  chk_sel1_reserved: assert property (
    rd_at(IDX_SEL1) |=> reg_rvalid && reg_rdata[7:3] == 5'h00)
    else $error("select 1 reserved bits set");
  chk_en2_reserved: assert property (
    rd_at(IDX_EN2) |=> reg_rvalid && reg_rdata[7:1] == 7'h00)
    else $error("enable 2 reserved bits set");
  chk_size_bound: assert property (
    rd_at(IDX_CO_SIZE) |=> reg_rvalid && reg_rdata[31:8] == 24'h0 && reg_rdata[7:0] <= 8'h08)
    else $error("control out size out of range");
  chk_dma_lane: assert property (
    reg_rd && reg_addr == IDX_B1_FIFO && reg_byte |=> reg_rvalid && reg_rdata[31:8] == 24'h0)
    else $error("byte mode used upper lanes");
  chk_masked_quiet: assert property (
    sh.en0 == 8'h00 && sh.en1 == 3'h0 |-> !irq_line_zero && !irq_line_one)
    else $error("irq line without enable");
  chk_hp_gated: assert property (
    !sh.en2 |-> !irq_line_high_priority)
    else $error("high priority line without enable");
  chk_route_zero: assert property (
    sh.sel0 == 8'h00 && sh.sel1 == 3'h0 |-> !irq_line_one)
    else $error("line one with all selects clear");
  chk_route_one: assert property (
    sh.sel0 == 8'hff && sh.sel1 == 3'h7 |-> !irq_line_zero)
    else $error("line zero with all selects set");
endmodule

// File: tb.sv
`timescale 1ns/10ps
module tb;
  import usbf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic bus_reset_event = 1'b0, connect_event = 1'b0, set_config_event = 1'b0;
  logic rx_valid = 1'b0, rx_last = 1'b0, tx_token = 1'b0, tx_pop = 1'b0, tx_ack = 1'b0;
  logic [1:0] rx_kind = 2'h0, tx_ep = 2'h0;
  logic [7:0] rx_data = 8'h00;
  logic rx_ready, tx_avail, awready, wready, bvalid, arready, rvalid;
  logic [6:0] tx_len;
  logic [7:0] tx_data;
  logic [6:0] awaddr = 7'h00, araddr = 7'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp, wr_resp;
  int fail_count = 0;
  int n_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  usbf_if bus_if();
  usbf_device usbf_device_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus_if.device),
    .bus_reset_event(bus_reset_event), .connect_event(connect_event),
    .set_config_event(set_config_event), .rx_valid(rx_valid), .rx_kind(rx_kind),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_ep(tx_ep),
    .tx_token(tx_token), .tx_pop(tx_pop), .tx_ack(tx_ack), .tx_avail(tx_avail),
    .tx_len(tx_len), .tx_data(tx_data));
  usbf_controller usbf_controller_inst (.sys_clk(sys_clk), .rst(rst),
    .dev(bus_if.controller), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  usbf_props usbf_props_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(bus_if.reg_addr),
    .reg_wdata(bus_if.reg_wdata), .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd),
    .reg_byte(bus_if.reg_byte), .reg_rdata(bus_if.reg_rdata),
    .reg_rvalid(bus_if.reg_rvalid), .irq_line_zero(bus_if.irq_line_zero),
    .irq_line_one(bus_if.irq_line_one),
    .irq_line_high_priority(bus_if.irq_line_high_priority));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Handshakes are looked at on the falling edge, where inputs and state are settled
  task automatic axi_wr(input logic [4:0] idx, input logic [31:0] d);
    int n;
    logic a, w, b;
    n = 0;
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      a = awready;
      w = wready;
      b = bvalid;
      wr_resp = bresp;
      @(posedge sys_clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
    end while (!b && n < 40);
    bready <= 1'b0;
    if (!b) begin
      check("write answer", 32'h0, 32'h1);
      complete_run();
    end
  endtask
  task automatic axi_rd(input logic [4:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic a, v;
    n = 0;
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      a = arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (a) arvalid <= 1'b0;
      n++;
    end while (!v && n < 40);
    rready <= 1'b0;
    if (!v) begin
      check("read answer", 32'h0, 32'h1);
      complete_run();
    end
  endtask
  task automatic rd_chk(input string what, input logic [4:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(idx, d, r);
    check(what, d, exp);
  endtask
  task automatic stat_chk(input logic [2:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(IDX_STATUS, d, r);
    check("irq lines", {29'h0, d[2:0]}, {29'h0, exp});
  endtask
  task automatic rx_send(input logic [1:0] k, input int n, input logic [7:0] b0);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_kind <= k;
      rx_data <= b0 + 8'(i);
      rx_last <= (i == n - 1);
      @(negedge sys_clk);
      check("rx_ready", 32'(rx_ready), 32'h1);
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask
  task automatic tx_run(input logic [1:0] ep, input logic [6:0] len, input logic [7:0] b0);
    @(posedge sys_clk);
    tx_ep <= ep;
    tx_token <= 1'b1;
    @(posedge sys_clk);
    tx_token <= 1'b0;
    @(negedge sys_clk);
    check("tx_avail", 32'(tx_avail), 32'h1);
    check("tx_len", 32'(tx_len), 32'(len));
    check("tx byte 0", 32'(tx_data), 32'(b0));
    @(posedge sys_clk);
    tx_pop <= 1'b1;
    @(posedge sys_clk);
    tx_pop <= 1'b0;
    tx_ack <= 1'b1;
    @(negedge sys_clk);
    check("tx byte 1", 32'(tx_data), 32'(b0 + 8'h01));
    @(posedge sys_clk);
    tx_ack <= 1'b0;
  endtask
  task automatic test_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk("sel0", IDX_SEL0, 32'h00);
    rd_chk("sel1", IDX_SEL1, 32'h07);
    rd_chk("en0", IDX_EN0, 32'h00);
    rd_chk("en1", IDX_EN1, 32'h00);
    rd_chk("en2", IDX_EN2, 32'h00);
    axi_wr(IDX_CO_SIZE, 32'h55);
    rd_chk("co size", IDX_CO_SIZE, 32'h00);
    axi_wr(IDX_SEL1, 32'hff);
    rd_chk("sel1 reserved", IDX_SEL1, 32'h07);
    axi_wr(5'h12, 32'h01);
    check("unmapped write resp", 32'(wr_resp), 32'(RESP_SLVERR));
    axi_rd(5'h12, d, r);
    check("unmapped resp", 32'(r), 32'(RESP_SLVERR));
    $display("test_reset done");
  endtask
  task automatic test_irq();
    @(posedge sys_clk);
    bus_reset_event <= 1'b1;
    connect_event <= 1'b1;
    @(posedge sys_clk);
    bus_reset_event <= 1'b0;
    connect_event <= 1'b0;
    stat_chk(3'h0);
    axi_wr(IDX_EN0, 32'h80);
    stat_chk(3'h1);
    axi_wr(IDX_SEL0, 32'h80);
    axi_wr(IDX_EN1, 32'h01);
    stat_chk(3'h2);
    axi_wr(IDX_SEL1, 32'h00);
    stat_chk(3'h3);
    axi_wr(IDX_FLG0, 32'h7f);
    stat_chk(3'h1);
    axi_wr(IDX_SEL0, 32'h00);
    axi_wr(IDX_SEL0, 32'hff);
    axi_wr(IDX_SEL1, 32'h07);
    stat_chk(3'h2);
    axi_wr(IDX_FLG1, 32'h06);
    @(posedge sys_clk);
    set_config_event <= 1'b1;
    @(posedge sys_clk);
    set_config_event <= 1'b0;
    stat_chk(3'h0);
    axi_wr(IDX_EN2, 32'h01);
    stat_chk(3'h4);
    axi_wr(IDX_FLG2, 32'h00);
    stat_chk(3'h0);
    $display("test_irq done");
  endtask
  task automatic test_ctrl_out();
    rx_send(RX_CTRL_OUT, 3, 8'h10);
    rd_chk("co flag", IDX_FLG0, 32'h04);
    rd_chk("co size", IDX_CO_SIZE, 32'h03);
    rd_chk("co byte", IDX_CO_FIFO, 32'h10);
    @(negedge sys_clk);
    check("co held", 32'(rx_ready), 32'h0);
    axi_wr(IDX_TRIG, 32'h02);
    @(negedge sys_clk);
    check("co freed", 32'(rx_ready), 32'h1);
    axi_wr(IDX_FLG0, 32'h00);
    rx_send(RX_AUTO, 8, 8'h40);
    rd_chk("auto kept out", IDX_FLG0, 32'h00);
    rx_send(RX_SETUP, 8, 8'h20);
    rd_chk("setup flag", IDX_FLG0, 32'h08);
    rd_chk("setup byte", IDX_SU_FIFO, 32'h20);
    rx_send(RX_SETUP, 8, 8'h30);
    rd_chk("setup overwrite", IDX_SU_FIFO, 32'h30);
    axi_wr(IDX_FLG0, 32'h00);
    $display("test_ctrl_out done");
  endtask
  task automatic test_tx();
    for (int i = 0; i < 8; i++) begin
      axi_wr(IDX_CI_FIFO, 32'h50 + 32'(i));
    end
    axi_wr(IDX_TRIG, 32'h01);
    tx_run(TX_CTRL, 7'h08, 8'h50);
    rd_chk("ci done", IDX_FLG0, 32'h01);
    axi_wr(IDX_I3_FIFO, 32'h60);
    axi_wr(IDX_I3_FIFO, 32'h61);
    axi_wr(IDX_TRIG, 32'h40);
    tx_run(TX_INTR, 7'h02, 8'h60);
    rd_chk("i3 done", IDX_FLG1, 32'h02);
    axi_wr(IDX_FLG0, 32'h00);
    axi_wr(IDX_B2_FIFO, 32'h73727170);
    axi_wr(IDX_TRIG, 32'h10);
    tx_run(TX_BULK, 7'h04, 8'h70);
    rd_chk("b2 empty", IDX_FLG0, 32'h10);
    axi_wr(IDX_FLG0, 32'h00);
    $display("test_tx done");
  endtask
  task automatic test_bulk_out();
    rx_send(RX_BULK, 5, 8'h80);
    rd_chk("b1 full", IDX_FLG0, 32'h40);
    rd_chk("b1 size", IDX_B1_SIZE, 32'h05);
    rd_chk("b1 word", IDX_B1_FIFO, 32'h83828180);
    axi_wr(IDX_CTRL, 32'h01);
    rd_chk("b1 byte", IDX_B1_FIFO, 32'h84);
    axi_wr(IDX_CTRL, 32'h00);
    axi_wr(IDX_TRIG, 32'h20);
    rd_chk("b1 freed", IDX_B1_SIZE, 32'h00);
    rx_send(RX_BULK, 2, 8'h90);
    rd_chk("b1 second", IDX_B1_SIZE, 32'h02);
    axi_wr(IDX_FCLR, 32'h04);
    rd_chk("b1 cleared", IDX_B1_SIZE, 32'h00);
    $display("test_bulk_out done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_irq();
    test_ctrl_out();
    test_tx();
    test_bulk_out();
    complete_run();
  end
endmodule
